/* File: hdl/pmcr_regs.svh */
// register map, field positions, reset values and voltage steps of the
// mode-setting configuration bank; included by the package users
`ifndef PMCR_REGS_SVH
`define PMCR_REGS_SVH

// register offsets on the device register port
`define PMCR_ADDR_M0_PART2   8'h24
`define PMCR_ADDR_M0_PART3   8'h25
`define PMCR_ADDR_M1_PART0   8'h26

// reset values
`define PMCR_RST_M0_PART2    8'h4f
`define PMCR_RST_M0_PART3    8'h39
`define PMCR_RST_M1_PART0    8'h1c

// mode-0 part-2 fields
`define PMCR_AON_CODE_HI     7
`define PMCR_AON_CODE_LO     4
`define PMCR_AON_EN_BIT      1
`define PMCR_SYS_EN_BIT      0

// mode-0 part-3 fields
`define PMCR_WD_HI           7
`define PMCR_WD_LO           6
`define PMCR_SYS_OFS_BIT     5
`define PMCR_SYS_CODE_HI     4
`define PMCR_SYS_CODE_LO     0

// mode-1 part-0 fields
`define PMCR_SHIP_BIT        7
`define PMCR_SRC_PIN_BIT     6
`define PMCR_CORE_CODE_HI    5
`define PMCR_CORE_CODE_LO    0

// voltage ladders in millivolts
`define PMCR_STEP_MV         12'd25
`define PMCR_AON_BASE_MV     12'd1700
`define PMCR_AON_MAX_CODE    4'h8
`define PMCR_AON_MAX_MV      12'd1900
`define PMCR_SYS_BASE_MV     12'd1500
`define PMCR_SYS_MAX_CODE    5'h18
`define PMCR_SYS_MAX_MV      12'd2100
`define PMCR_SYS_OFS_MV      12'd1200
`define PMCR_CORE_BASE_MV    12'd500
`define PMCR_CORE_MAX_CODE   6'h28
`define PMCR_CORE_MAX_MV     12'd1500
`define PMCR_CORE_FIX_CODE   6'h3f
`define PMCR_CORE_FIX_MV     12'd1800

// watchdog timeout figures in seconds
`define PMCR_WD_OFF_S        7'd0
`define PMCR_WD_SEL1_S       7'd16
`define PMCR_WD_SEL2_S       7'd32
`define PMCR_WD_SEL3_S       7'd64

`endif

/* File: hdl/pmcr_pkg.sv */
// types shared by the mode-setting configuration bank
// assumes nothing beyond a SystemVerilog compiler
package pmcr_pkg;

    // watchdog timeout selection codes
    typedef enum logic [1:0] {
        PMCR_WD_DISABLED = 2'h0,
        PMCR_WD_16S      = 2'h1,
        PMCR_WD_32S      = 2'h2,
        PMCR_WD_64S      = 2'h3
    } pmcr_wd_sel_t;

    // complete state of the register bank
    typedef struct packed {
        logic [7:0]  m0_part2;
        logic [7:0]  m0_part3;
        logic [7:0]  m1_part0;
        logic [1:0]  pin_a_sync;
        logic [1:0]  pin_b_sync;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [1:0]  mode_sel;
        logic [11:0] aon_mv;
        logic [11:0] sys_mv;
        logic [11:0] core_mv;
        logic [6:0]  wd_s;
    } pmcr_state_t;

endpackage

/* File: hdl/pmcr_volt_decode.sv */
// code-to-millivolt translation for the three regulator codes
// assumes codes come from registers on the same clock; purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "pmcr_regs.svh"

module pmcr_volt_decode
    import pmcr_pkg::*;
(
    // register codes
    input  wire logic [3:0]  aon_code,
    input  wire logic [4:0]  sys_code,
    input  wire logic        sys_offset,
    input  wire logic [5:0]  core_code,
    // decoded targets
    output logic      [11:0] aon_mv,
    output logic      [11:0] sys_mv,
    output logic      [11:0] core_mv
);

    // ladders saturate at their top step; core top code is a fixed rail
    always_comb begin
        if (aon_code > `PMCR_AON_MAX_CODE) begin
            aon_mv = `PMCR_AON_MAX_MV;
        end else begin
            aon_mv = `PMCR_AON_BASE_MV + 12'(aon_code) * `PMCR_STEP_MV;
        end
        if (sys_code > `PMCR_SYS_MAX_CODE) begin
            sys_mv = `PMCR_SYS_MAX_MV;
        end else begin
            sys_mv = `PMCR_SYS_BASE_MV + 12'(sys_code) * `PMCR_STEP_MV;
        end
        if (sys_offset) begin
            sys_mv = sys_mv + `PMCR_SYS_OFS_MV;
        end
        if (core_code == `PMCR_CORE_FIX_CODE) begin
            core_mv = `PMCR_CORE_FIX_MV;
        end else if (core_code > `PMCR_CORE_MAX_CODE) begin
            core_mv = `PMCR_CORE_MAX_MV;
        end else begin
            core_mv = `PMCR_CORE_BASE_MV + 12'(core_code) * `PMCR_STEP_MV;
        end
    end

endmodule
`default_nettype wire

/* File: hdl/pmcr_mode_cfg.sv */
// mode-setting configuration register bank with decoded regulator targets
// assumes the serial front end hands over byte accesses on clk_sys and
// that one-time-programmed defaults are stable while reset is high
//
// Function
// - part-2 bit 1 enables the always-on regulator in mode 0 and resets to one.
// - part-2 bit 0 enables the system linear regulator in mode 0 and resets to one.
// - the 4-bit always-on code steps 25 mV from 1.700 V to 1.900 V, saturates, resets 0100.
// - part-3 bits 7:6 pick watchdog off, 16 s, 32 s or 64 s and reset to 00.
// - part-3 bit 5 adds 1.2 V to the system linear regulator target and resets to one.
// - the 5-bit system code runs 1.500 V in 25 mV steps to 2.100 V and saturates above.
// - the system code resets to 11001, giving 3.3 V with the offset, and may come from OTP.
// - mode-1 part-0 bit 7 requests ship mode when one and resets to zero.
// - mode-1 part-0 bit 6 picks the select pins when one and the register bits when zero.
// - the 6-bit core buck code runs 0.500 V in 25 mV steps and resets to 011100.
// - mode-0 part-3 sits at 25h and is read-write.
// - mode-1 part-0 sits at 26h and is read-write.
// - enable bits and the watchdog field may take their reset value from OTP.
// - core codes 101001 to 111110 give 1.5 V and 111111 gives a fixed 1.8 V.
`timescale 1ns/10ps
`default_nettype none
`include "pmcr_regs.svh"

module pmcr_mode_cfg
    import pmcr_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // register port from the serial front end
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rd_valid,
    // one-time-programmed defaults
    input  wire logic        otp_use,
    input  wire logic [7:0]  otp_m0_part2,
    input  wire logic [7:0]  otp_m0_part3,
    // mode select sources
    input  wire logic        mode_select_pin_a,
    input  wire logic        mode_select_pin_b,
    input  wire logic        mode_select_bit_a,
    input  wire logic        mode_select_bit_b,
    // configuration outputs
    output logic             aon_reg_enable_m0,
    output logic             sys_linreg_enable_m0,
    output logic [3:0]       aon_reg_code_m0,
    output logic [1:0]       watchdog_timeout_sel_m0,
    output logic [6:0]       watchdog_timeout_s_m0,
    output logic             sys_linreg_offset_m0,
    output logic [4:0]       sys_linreg_code_m0,
    output logic             ship_mode_request,
    output logic             mode_source_pin_m1,
    output logic [5:0]       core_buck_code_m1,
    output logic [1:0]       active_mode_sel,
    // decoded targets in millivolts
    output logic [11:0]      aon_target_mv,
    output logic [11:0]      sys_target_mv,
    output logic [11:0]      core_target_mv
);

    pmcr_state_t st;
    pmcr_state_t next_st;
    logic [11:0] dec_aon_mv;
    logic [11:0] dec_sys_mv;
    logic [11:0] dec_core_mv;

    // true when the port addresses the given register
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction

    // watchdog selection to seconds
    function automatic logic [6:0] wd_seconds(input logic [1:0] sel);
        logic [6:0] s;
        s = `PMCR_WD_OFF_S;
        unique case (pmcr_wd_sel_t'(sel))
            PMCR_WD_DISABLED: s = `PMCR_WD_OFF_S;
            PMCR_WD_16S:      s = `PMCR_WD_SEL1_S;
            PMCR_WD_32S:      s = `PMCR_WD_SEL2_S;
            PMCR_WD_64S:      s = `PMCR_WD_SEL3_S;
        endcase
        return s;
    endfunction

    // decode from the stored codes, so targets lag a write by one cycle
    pmcr_volt_decode u_decode (
        .aon_code   (st.m0_part2[`PMCR_AON_CODE_HI:`PMCR_AON_CODE_LO]),
        .sys_code   (st.m0_part3[`PMCR_SYS_CODE_HI:`PMCR_SYS_CODE_LO]),
        .sys_offset (st.m0_part3[`PMCR_SYS_OFS_BIT]),
        .core_code  (st.m1_part0[`PMCR_CORE_CODE_HI:`PMCR_CORE_CODE_LO]),
        .aon_mv     (dec_aon_mv),
        .sys_mv     (dec_sys_mv),
        .core_mv    (dec_core_mv)
    );

    // next-state logic: register writes, reads, pin synchronisers, outputs
    always_comb begin
        next_st = st;
        // pins are asynchronous; only the second stage is read downstream
        next_st.pin_a_sync = {st.pin_a_sync[0], mode_select_pin_a};
        next_st.pin_b_sync = {st.pin_b_sync[0], mode_select_pin_b};
        if (reg_wr_en) begin
            if (reg_hit(reg_addr, `PMCR_ADDR_M0_PART2)) begin
                next_st.m0_part2 = reg_wdata;
            end
            if (reg_hit(reg_addr, `PMCR_ADDR_M0_PART3)) begin
                next_st.m0_part3 = reg_wdata;
            end
            if (reg_hit(reg_addr, `PMCR_ADDR_M1_PART0)) begin
                next_st.m1_part0 = reg_wdata;
            end
        end
        // reads answer one cycle later; unmapped addresses read zero
        next_st.rvalid = reg_rd_en;
        if (reg_rd_en) begin
            if (reg_hit(reg_addr, `PMCR_ADDR_M0_PART2)) begin
                next_st.rdata = st.m0_part2;
            end else if (reg_hit(reg_addr, `PMCR_ADDR_M0_PART3)) begin
                next_st.rdata = st.m0_part3;
            end else if (reg_hit(reg_addr, `PMCR_ADDR_M1_PART0)) begin
                next_st.rdata = st.m1_part0;
            end else begin
                next_st.rdata = 8'h00;
            end
        end
        // source select: pins and register bits never mix
        if (st.m1_part0[`PMCR_SRC_PIN_BIT]) begin
            next_st.mode_sel = {st.pin_b_sync[1], st.pin_a_sync[1]};
        end else begin
            next_st.mode_sel = {mode_select_bit_b, mode_select_bit_a};
        end
        next_st.aon_mv  = dec_aon_mv;
        next_st.sys_mv  = dec_sys_mv;
        next_st.core_mv = dec_core_mv;
        next_st.wd_s    = wd_seconds(st.m0_part3[`PMCR_WD_HI:`PMCR_WD_LO]);
        // synchronous reset; otp values load here, never from an async path
        if (reset) begin
            next_st = '0;
            next_st.m0_part2 = otp_use ? otp_m0_part2 : `PMCR_RST_M0_PART2;
            next_st.m0_part3 = otp_use ? otp_m0_part3 : `PMCR_RST_M0_PART3;
            next_st.m1_part0 = `PMCR_RST_M1_PART0;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        st <= next_st;
    end

    // outputs straight from flops
    assign reg_rdata               = st.rdata;
    assign reg_rd_valid            = st.rvalid;
    assign aon_reg_enable_m0       = st.m0_part2[`PMCR_AON_EN_BIT];
    assign sys_linreg_enable_m0    = st.m0_part2[`PMCR_SYS_EN_BIT];
    assign aon_reg_code_m0         = st.m0_part2[`PMCR_AON_CODE_HI:`PMCR_AON_CODE_LO];
    assign watchdog_timeout_sel_m0 = st.m0_part3[`PMCR_WD_HI:`PMCR_WD_LO];
    assign watchdog_timeout_s_m0   = st.wd_s;
    assign sys_linreg_offset_m0    = st.m0_part3[`PMCR_SYS_OFS_BIT];
    assign sys_linreg_code_m0      = st.m0_part3[`PMCR_SYS_CODE_HI:`PMCR_SYS_CODE_LO];
    assign ship_mode_request       = st.m1_part0[`PMCR_SHIP_BIT];
    assign mode_source_pin_m1      = st.m1_part0[`PMCR_SRC_PIN_BIT];
    assign core_buck_code_m1       = st.m1_part0[`PMCR_CORE_CODE_HI:`PMCR_CORE_CODE_LO];
    assign active_mode_sel         = st.mode_sel;
    assign aon_target_mv           = st.aon_mv;
    assign sys_target_mv           = st.sys_mv;
    assign core_target_mv          = st.core_mv;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    aon_enable_default_a: assert property (
        $fell(reset) && !otp_use |-> aon_reg_enable_m0 && sys_linreg_enable_m0 && !ship_mode_request)
        else $error("enable or ship defaults wrong after reset");
    sys_enable_write_a: assert property (
        reg_wr_en && reg_addr == 8'h24 |=> sys_linreg_enable_m0 == $past(reg_wdata[0]))
        else $error("system regulator enable did not follow write");
    aon_saturate_a: assert property (
        aon_reg_code_m0 > 4'h8 |=> aon_target_mv == 12'd1900)
        else $error("always-on target not saturated");
    wd_seconds_a: assert property (
        watchdog_timeout_sel_m0 == 2'h2 ##1 watchdog_timeout_sel_m0 == 2'h2
        |-> watchdog_timeout_s_m0 == 7'd32)
        else $error("watchdog seconds mismatch");
    sys_default_volt_a: assert property (
        $fell(reset) && !otp_use |=> sys_target_mv == 12'd3300)
        else $error("system regulator default not 3.3 V");
    ship_write_a: assert property (
        reg_wr_en && reg_addr == 8'h26 |=> ship_mode_request == $past(reg_wdata[7]))
        else $error("ship request did not follow write");
    pin_source_a: assert property (
        (mode_source_pin_m1 && $stable(mode_select_pin_a)) [*4]
        |-> active_mode_sel[0] == mode_select_pin_a)
        else $error("pin source not selected");
    core_fixed_a: assert property (
        core_buck_code_m1 == 6'h3f |=> core_target_mv == 12'd1800)
        else $error("core fixed rail not decoded");
    readback_a: assert property (
        reg_wr_en && reg_addr == 8'h25 ##1 reg_rd_en && reg_addr == 8'h25 && !reg_wr_en
        |=> reg_rd_valid && reg_rdata == $past(reg_wdata, 2))
        else $error("readback differs from last write");
    unmapped_read_a: assert property (
        reg_rd_en && reg_addr > 8'h26 |=> reg_rd_valid && reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // decode, write and default checks; targets lag their codes by one cycle
    offset_add_a: assert property (
        sys_linreg_offset_m0 && sys_linreg_code_m0 == 5'h00 |=> sys_target_mv == 12'd2700)
        else $error("system regulator offset not added");
    sys_ladder_top_a: assert property (
        !sys_linreg_offset_m0 && sys_linreg_code_m0 == 5'h18 |=> sys_target_mv == 12'd2100)
        else $error("system regulator top step wrong");
    core_default_a: assert property (
        core_buck_code_m1 == 6'h1c |=> core_target_mv == 12'd1200)
        else $error("core buck default step wrong");
    part3_write_a: assert property (
        reg_wr_en && reg_addr == 8'h25 |=> sys_linreg_code_m0 == $past(reg_wdata[4:0]))
        else $error("part three write not stored");
    otp_defaults_a: assert property (
        $fell(reset) && otp_use |-> watchdog_timeout_sel_m0 == $past(otp_m0_part3[7:6])
            && aon_reg_enable_m0 == $past(otp_m0_part2[1]))
        else $error("otp defaults not loaded");

endmodule
`default_nettype wire

/* File: verification/pmcr_host_model.sv */
// host model issuing byte accesses on the mode bank register port
// assumes clk_sys from the bench; drives only on the falling edge
`timescale 1ns/10ps
`default_nettype none

module pmcr_host_model (
    // clock
    input  wire logic       clk_sys,
    // register port
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid
);
    logic timed_out;

    // idle port at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        timed_out = 1'b0;
    end

    // one-cycle strobe; data inverted after release so a stale hold shows
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_wdata = ~data;
    endtask

    // read pulse, then a bounded wait for the answer
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        int n;
        @(negedge clk_sys);
        reg_addr  = addr;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        n = 0;
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        if (reg_rd_valid !== 1'b1) begin
            timed_out = 1'b1;
        end
        data = reg_rdata;
    endtask

    // write strobe followed at once by a read of the same byte
    task automatic write_read(input logic [7:0] addr,
                              input logic [7:0] wdat,
                              output logic [7:0] data);
        @(negedge clk_sys);
        reg_addr  = addr;
        reg_wdata = wdat;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        reg_wdata = ~wdat;
        if (reg_rd_valid !== 1'b1) begin
            timed_out = 1'b1;
        end
        data = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: verification/pmcr_tb_top.sv */
// testbench for the mode-setting configuration bank
// assumes the host model drives the register port; bench drives the rest
`timescale 1ns/10ps
`default_nettype none

module pmic_mode_setting_config_regs_tb_top
    import pmcr_pkg::*;
;
    logic        clk_sys, reset, otp_use;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, otp_m0_part2, otp_m0_part3;
    logic        reg_wr_en, reg_rd_en, reg_rd_valid;
    logic        mode_select_pin_a, mode_select_pin_b, mode_select_bit_a, mode_select_bit_b;
    logic        aon_reg_enable_m0, sys_linreg_enable_m0, sys_linreg_offset_m0;
    logic        ship_mode_request, mode_source_pin_m1;
    logic [3:0]  aon_reg_code_m0;
    logic [1:0]  watchdog_timeout_sel_m0, active_mode_sel;
    logic [6:0]  watchdog_timeout_s_m0;
    logic [4:0]  sys_linreg_code_m0;
    logic [5:0]  core_buck_code_m1;
    logic [11:0] aon_target_mv, sys_target_mv, core_target_mv;
    int          mismatches, compares;
    logic [7:0]  rd_back;
    logic [7:0]  t_addr[15] = '{8'h24, 8'h24, 8'h24, 8'h24, 8'h24, 8'h25, 8'h25, 8'h25,
                                8'h25, 8'h25, 8'h26, 8'h26, 8'h26, 8'h26, 8'h26};
    logic [7:0]  t_data[15] = '{8'h03, 8'h13, 8'h83, 8'h93, 8'hf3, 8'h00, 8'h18, 8'h1f,
                                8'h20, 8'h21, 8'h00, 8'h28, 8'h29, 8'h3e, 8'h3f};
    logic [11:0] t_mv[15]   = '{12'h6a4, 12'h6bd, 12'h76c, 12'h76c, 12'h76c, 12'h5dc,
                                12'h834, 12'h834, 12'ha8c, 12'haa5, 12'h1f4, 12'h5dc,
                                12'h5dc, 12'h5dc, 12'h708};
    logic [6:0]  wd_tab[4]  = '{7'h00, 7'h10, 7'h20, 7'h40};

    pmcr_mode_cfg dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
        .reg_rdata, .reg_rd_valid, .otp_use, .otp_m0_part2, .otp_m0_part3,
        .mode_select_pin_a, .mode_select_pin_b, .mode_select_bit_a, .mode_select_bit_b,
        .aon_reg_enable_m0, .sys_linreg_enable_m0, .aon_reg_code_m0, .watchdog_timeout_sel_m0,
        .watchdog_timeout_s_m0, .sys_linreg_offset_m0, .sys_linreg_code_m0,
        .ship_mode_request, .mode_source_pin_m1, .core_buck_code_m1, .active_mode_sel,
        .aon_target_mv, .sys_target_mv, .core_target_mv);

    pmcr_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
        .reg_rdata, .reg_rd_valid);

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic summarize();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // a lost read answer ends the run at once
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(addr, d);
        check(d, exp, "read data");
        if (host.timed_out) begin
            mismatches++;
            summarize();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // reset held five cycles, released off the sampling edge
    task automatic do_reset();
        reset = 1'b1;
        cyc(5);
        reset = 1'b0;
        cyc(2);
    endtask

    // main sequence
    initial begin
        mismatches = 0;
        compares = 0;
        {reset, otp_use, otp_m0_part2, otp_m0_part3} = {2'h2, 16'h0000};
        {mode_select_pin_a, mode_select_pin_b, mode_select_bit_a, mode_select_bit_b} = 4'h0;
        do_reset();
        check(aon_reg_enable_m0, 1'b1, "aon enable");
        check(sys_linreg_enable_m0, 1'b1, "sys enable");
        check(aon_target_mv, 12'h708, "aon default");
        check(watchdog_timeout_s_m0, 7'h00, "wd default");
        check(sys_linreg_offset_m0, 1'b1, "offset default");
        check(sys_target_mv, 12'hce4, "sys default");
        check(ship_mode_request, 1'b0, "ship default");
        check(core_target_mv, 12'h4b0, "core default");
        check(aon_reg_code_m0, 4'h4, "aon code default");
        check(sys_linreg_code_m0, 5'h19, "sys code default");
        check(core_buck_code_m1, 6'h1c, "core code default");
        check(mode_source_pin_m1, 1'b0, "source default");
        rd_chk(8'h24, 8'h4f);
        rd_chk(8'h25, 8'h39);
        rd_chk(8'h26, 8'h1c);
        host.write_reg(8'h24, 8'h02);
        check({aon_reg_enable_m0, sys_linreg_enable_m0}, 2'h2, "enables");
        host.write_reg(8'h24, 8'h01);
        check({aon_reg_enable_m0, sys_linreg_enable_m0}, 2'h1, "enables");
        for (int i = 0; i < 4; i++) begin
            host.write_reg(8'h25, {i[1:0], 6'h00});
            cyc(1);
            check(watchdog_timeout_sel_m0, i[1:0], "wd field");
            check(watchdog_timeout_s_m0, wd_tab[i], "wd seconds");
        end
        for (int i = 0; i < 15; i++) begin
            host.write_reg(t_addr[i], t_data[i]);
            cyc(1);
            check(t_addr[i] == 8'h24 ? aon_target_mv : t_addr[i] == 8'h25 ? sys_target_mv
                : core_target_mv, t_mv[i], "target");
            rd_chk(t_addr[i], t_data[i]);
        end
        host.write_reg(8'h26, 8'h80);
        {mode_select_pin_a, mode_select_bit_b} = 2'h3;
        cyc(1);
        check({ship_mode_request, active_mode_sel}, 3'h6, "bits select");
        host.write_reg(8'h26, 8'h40);
        cyc(4);
        check({ship_mode_request, active_mode_sel}, 3'h1, "pins select");
        check(mode_source_pin_m1, 1'b1, "source pins");
        {mode_select_bit_a, mode_select_bit_b, mode_select_pin_b} = 3'h1;
        cyc(4);
        check(active_mode_sel, 2'h3, "bits ignored");
        host.write_reg(8'h27, 8'hff);
        rd_chk(8'h27, 8'h00);
        rd_chk(8'h26, 8'h40);
        host.write_read(8'h25, 8'h5a, rd_back);
        check(rd_back, 8'h5a, "write then read");
        check(sys_linreg_code_m0, 5'h1a, "sys code written");
        {otp_use, otp_m0_part2, otp_m0_part3} = {1'b1, 16'h0040};
        do_reset();
        check({aon_reg_enable_m0, sys_linreg_enable_m0}, 2'h0, "otp enables");
        check(watchdog_timeout_s_m0, 7'h10, "otp wd");
        rd_chk(8'h25, 8'h40);
        rd_chk(8'h26, 8'h1c);
        summarize();
    end
endmodule
`default_nettype wire
